// [core/sfrs_link.sv]
// Link-side opcode capture on the serial clock
`timescale 1ns/100ps
module sfrs_link
    import sfrs_pkg::*;
(
    // Link clock and frame
    input wire logic sck,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic si,
    // Toward the core domain
    output logic op_tgl,
    output logic [OPC_W-1:0] opcode
);

    logic [BITCNT_W-1:0] bit_r;
    logic [BITCNT_W-1:0] bit_nxt;
    logic [OPC_W-1:0] shift_r;
    logic [OPC_W-1:0] shift_nxt;
    logic done_r;
    logic done_nxt;
    logic tgl_r;
    logic tgl_nxt;
    logic [OPC_W-1:0] op_r;
    logic [OPC_W-1:0] op_nxt;

    // Shift the first byte of a frame, then toggle once
    always_comb begin
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        done_nxt = done_r;
        tgl_nxt = tgl_r;
        op_nxt = op_r;
        if (!done_r) begin
            shift_nxt = {shift_r[OPC_W-2:0], si};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == 3'h7) begin
                done_nxt = 1'b1;
                op_nxt = {shift_r[OPC_W-2:0], si};
                tgl_nxt = ~tgl_r;
            end
        end
    end

    // Frame state cleared by select going high, no serial clock edge needed
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            bit_r <= 3'h0;
            shift_r <= OPC_RST;
            done_r <= 1'b0;
        end else begin
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            done_r <= done_nxt;
        end
    end

    // Opcode word and event toggle survive between frames
    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            tgl_r <= 1'b0;
            op_r <= OPC_RST;
        end else begin
            tgl_r <= tgl_nxt;
            op_r <= op_nxt;
        end
    end

    assign op_tgl = tgl_r;
    assign opcode = op_r;

endmodule

// [core/sfrs_pkg.sv]
// Shared constants and types for the serial flash reset sequencer
package sfrs_pkg;

    // Core clock rate
    localparam int CLK_MHZ = 10;

    // Power-up wait, in microseconds (plain default, overridable at top)
    localparam int POWER_UP_WAIT_US = 300;
    localparam int POWER_UP_WAIT_CYC = POWER_UP_WAIT_US * CLK_MHZ;

    // Reset-to-select wait (warm process length), microseconds
    localparam int RESET_TO_SELECT_WAIT_US = 35;
    localparam int RESET_TO_SELECT_WAIT_CYC = RESET_TO_SELECT_WAIT_US * CLK_MHZ;

    // Least reset pulse width, nanoseconds, rounded up to cycles
    localparam int RESET_PULSE_WIDTH_NS = 200;
    localparam int RESET_PULSE_WIDTH_CYC =
        (RESET_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (RESET_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;

    // Host-side minimums, kept for reference by the far end
    localparam int RESET_HIGH_SETUP_NS = 50;
    localparam int RESET_RELEASE_HOLD_NS = 50;
    localparam int SELECT_HIGH_GAP_READ_NS = 10;
    localparam int SELECT_HIGH_GAP_PROG_NS = 50;

    // Counter width for sequencing periods
    localparam int CNT_W = 16;

    // Opcode width and link bit counter width
    localparam int OPC_W = 8;
    localparam int BITCNT_W = 3;

    // Synchronised pin vector layout
    localparam int PIN_VCC = 0;
    localparam int PIN_FAULT = 1;
    localparam int PIN_RST = 2;
    localparam int PIN_CS = 3;
    localparam int PIN_TGL = 4;
    localparam int PIN_W = 5;

    // Reset values
    localparam logic [OPC_W-1:0] OPC_RST = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_OFF   = 5'h01,
        ST_COLD  = 5'h02,
        ST_HELD  = 5'h04,
        ST_READY = 5'h08,
        ST_WARM  = 5'h10
    } sfrs_state_t;

    // Interface status carried to the outputs
    typedef struct packed {
        logic ready;
        logic standby;
        logic io_oe;
        logic por_ok;
    } sfrs_status_t;

    // Event pulses of the sequencer
    typedef struct packed {
        logic reg_init;
        logic abort;
        logic cmd_valid;
    } sfrs_event_t;

endpackage

// [core/sfrs_sync.sv]
// Two-flop synchroniser, one lane per bit
`timescale 1ns/100ps
module sfrs_sync
    import sfrs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [PIN_W-1:0] d,
    output logic [PIN_W-1:0] q
);

    logic [PIN_W-1:0] meta_r;
    logic [PIN_W-1:0] sync_r;

    // One lane of two flops per input bit
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_lane
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_r[gi] <= 1'b0;
                    sync_r[gi] <= 1'b0;
                end else begin
                    meta_r[gi] <= d[gi];
                    sync_r[gi] <= meta_r[gi];
                end
            end
        end
    endgenerate

    assign q = sync_r;

endmodule

// [core/sfrs_top.sv]
// Reset sequencer of the serial flash interface
//
// Function
// - Run full cold initialization for the power-up wait after supply good.
// - Reset pin is ignored while cold initialization runs.
// - Reset still low at power-up end holds device in reset until release.
// - Falling reset reinitializes registers with a warm process of 35 us.
// - If power-on failed, reset launches full cold initialization instead.
// - Reset low 200 ns aborts, floats outputs, ignores commands; standby still follows select and BUSY only.
// - Select high and nothing busy drops device to standby power.
`timescale 1ns/100ps
module sfrs_top
    import sfrs_pkg::*;
#(
    parameter int PU_CYC = POWER_UP_WAIT_CYC
)
(
    // Core clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Supply and power-on health
    input wire logic VCC_OK,
    input wire logic POR_FAULT,
    // Flash pins from the host
    input wire logic RESET_PIN_N,
    input wire logic CS_N,
    input wire logic SCK,
    input wire logic SI,
    // Array activity
    input wire logic BUSY,
    // Interface status
    output logic READY,
    output logic STANDBY,
    output logic IO_OE,
    output logic POR_OK,
    // Event pulses
    output logic REG_INIT,
    output logic ABORT,
    // Accepted command
    output logic CMD_VALID,
    output logic [OPC_W-1:0] CMD_OPCODE
);

    // Last count of each timed period
    localparam logic [CNT_W-1:0] PU_LAST = CNT_W'(PU_CYC - 1);
    localparam logic [CNT_W-1:0] RPH_LAST =
        CNT_W'(RESET_TO_SELECT_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] RP_LAST = CNT_W'(RESET_PULSE_WIDTH_CYC - 1);

    // Reset release, pin crossing and link word
    logic rst_meta_r;
    logic rst_meta_nxt;
    logic rst_sync_r;
    logic rst_sync_nxt;
    logic rst_n_i;
    logic link_tgl;
    logic [OPC_W-1:0] link_opc;
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic vcc_s;
    logic fault_s;
    logic rst_low_s;
    logic cs_high_s;
    logic tgl_s;

    // Sequencer, command and status state
    sfrs_state_t st_r;
    sfrs_state_t st_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [CNT_W-1:0] low_r;
    logic [CNT_W-1:0] low_nxt;
    logic por_ok_r;
    logic por_ok_nxt;
    logic tgl_d_r;
    logic tgl_d_nxt;
    sfrs_status_t stat_r;
    sfrs_status_t stat_nxt;
    sfrs_event_t ev_r;
    sfrs_event_t ev_nxt;
    logic [OPC_W-1:0] opc_r;
    logic [OPC_W-1:0] opc_nxt;
    // Command accepted this cycle
    logic cmd_take;

    // Reset release next values
    always_comb begin
        rst_meta_nxt = 1'b1;
        rst_sync_nxt = rst_meta_r;
    end

    // Reset release through two flops
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= rst_meta_nxt;
            rst_sync_r <= rst_sync_nxt;
        end
    end

    assign rst_n_i = rst_sync_r;

    // Link-side first-byte capture on the host clock
    sfrs_link u_link (
        .sck(SCK),
        .rst_n(rst_n_i),
        .cs_n(CS_N),
        .si(SI),
        .op_tgl(link_tgl),
        .opcode(link_opc)
    );

    // Pins and link toggle into the core domain
    always_comb begin
        pin_raw = '0;
        pin_raw[PIN_VCC] = VCC_OK;
        pin_raw[PIN_FAULT] = POR_FAULT;
        pin_raw[PIN_RST] = ~RESET_PIN_N;
        pin_raw[PIN_CS] = CS_N;
        pin_raw[PIN_TGL] = link_tgl;
    end

    sfrs_sync u_sync (
        .clk(CORE_CLK),
        .rst_n(rst_n_i),
        .d(pin_raw),
        .q(pin_s)
    );

    // Synchronised pin lanes
    assign vcc_s = pin_s[PIN_VCC];
    assign fault_s = pin_s[PIN_FAULT];
    assign rst_low_s = pin_s[PIN_RST];
    assign cs_high_s = pin_s[PIN_CS];
    assign tgl_s = pin_s[PIN_TGL];

    // Sequencer next state
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        low_nxt = low_r;
        por_ok_nxt = por_ok_r;
        ev_nxt = '0;
        case (st_r)
            ST_OFF: begin
                // Nothing runs until the supply is seen
                cnt_nxt = CNT_RST;
                low_nxt = CNT_RST;
                if (vcc_s) begin
                    st_nxt = ST_COLD;
                    ev_nxt.reg_init = 1'b1;
                end
            end
            ST_COLD: begin
                // Reset pin is not looked at until the end
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r >= PU_LAST) begin
                    // Fault pin is looked at once, at the end
                    por_ok_nxt = ~fault_s;
                    cnt_nxt = CNT_RST;
                    if (rst_low_s) begin
                        st_nxt = ST_HELD;
                    end else begin
                        st_nxt = ST_READY;
                    end
                end
            end
            ST_HELD: begin
                // Waits for the pin to rise, no count
                if (!rst_low_s) begin
                    st_nxt = ST_READY;
                end
            end
            ST_READY: begin
                // Filter reset glitches shorter than the pulse width
                if (rst_low_s) begin
                    low_nxt = low_r + 16'h0001;
                    if (low_r >= RP_LAST) begin
                        // Qualified pulse: abort and reinitialize
                        ev_nxt.abort = 1'b1;
                        ev_nxt.reg_init = 1'b1;
                        low_nxt = CNT_RST;
                        if (por_ok_r) begin
                            st_nxt = ST_WARM;
                            cnt_nxt = low_r + 16'h0001;
                        end else begin
                            st_nxt = ST_COLD;
                            cnt_nxt = CNT_RST;
                        end
                    end
                end else begin
                    low_nxt = CNT_RST;
                end
            end
            ST_WARM: begin
                // Hold period counted from the reset fall
                if (cnt_r < RPH_LAST) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end else if (!rst_low_s) begin
                    // Leaves only once the pin is high again
                    st_nxt = ST_READY;
                    cnt_nxt = CNT_RST;
                end
            end
            default: begin
                st_nxt = ST_OFF;
                cnt_nxt = CNT_RST;
                low_nxt = CNT_RST;
            end
        endcase
        // Supply loss overrides state, power-on health and reset events
        if (!vcc_s) begin
            st_nxt = ST_OFF;
            por_ok_nxt = 1'b0;
            ev_nxt.reg_init = 1'b0;
            ev_nxt.abort = 1'b0;
        end
        // Commands only taken while ready and staying ready
        cmd_take = (tgl_s != tgl_d_r) && (st_r == ST_READY) &&
            (st_nxt == ST_READY);
        ev_nxt.cmd_valid = cmd_take;
    end

    // Command word capture on a new link toggle
    always_comb begin
        tgl_d_nxt = tgl_s;
        opc_nxt = opc_r;
        if (cmd_take) begin
            // Word has stood still since the toggle, safe to copy
            opc_nxt = link_opc;
        end
    end

    // Status outputs
    always_comb begin
        stat_nxt.ready = (st_nxt == ST_READY);
        stat_nxt.por_ok = por_ok_nxt;
        // Outputs float outside ready or while deselected
        stat_nxt.io_oe = (st_nxt == ST_READY) & ~cs_high_s;
        stat_nxt.standby = cs_high_s & ~BUSY;
    end

    // Sequencer registers
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= ST_OFF;
            cnt_r <= CNT_RST;
            low_r <= CNT_RST;
            por_ok_r <= 1'b0;
            ev_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            low_r <= low_nxt;
            por_ok_r <= por_ok_nxt;
            ev_r <= ev_nxt;
        end
    end

    // Command registers
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tgl_d_r <= 1'b0;
            opc_r <= OPC_RST;
        end else begin
            tgl_d_r <= tgl_d_nxt;
            opc_r <= opc_nxt;
        end
    end

    // Status registers
    always_ff @(posedge CORE_CLK or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_r <= '0;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Registered outputs
    assign READY = stat_r.ready;
    assign STANDBY = stat_r.standby;
    assign IO_OE = stat_r.io_oe;
    assign POR_OK = stat_r.por_ok;
    assign REG_INIT = ev_r.reg_init;
    assign ABORT = ev_r.abort;
    assign CMD_VALID = ev_r.cmd_valid;
    assign CMD_OPCODE = opc_r;

endmodule

// [tb/sfrs_host_model.sv]
// Host controller model driving the flash pins
`timescale 1ns/100ps
module sfrs_host_model
(
    // Timing reference
    input wire logic clk,
    // Flash pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic reset_pin_n
);
    // Idle pins, nothing selected at power-up
    initial begin
        sck = 1'b0;
        si = 1'b0;
        reset_pin_n = 1'b1;
        // Late enough that the frame clear sees a rising select
        #1 cs_n = 1'b1;
    end
    // One opcode frame, serial clock only inside it
    task automatic frame(input logic [7:0] op);
        @(posedge clk);
        cs_n <= 1'b0;
        #30;
        for (int i = 7; i >= 0; i--) begin
            si = op[i];
            #7.5 sck = 1'b1;
            #7.5 sck = 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        si = ~si;
        repeat (5) @(posedge clk);
    endtask
    // Reset pin level at a clock edge
    task automatic set_rst(input logic v);
        @(posedge clk);
        reset_pin_n <= v;
    endtask
    // Reset pulse in whole cycles, select kept high
    task automatic pulse(input int low_cyc);
        set_rst(1'b0);
        repeat (low_cyc) @(posedge clk);
        reset_pin_n <= 1'b1;
    endtask
endmodule

// [tb/sfrs_top_checker.sv]
// Port assertions for the reset sequencer
`timescale 1ns/100ps
module sfrs_top_checker
    import sfrs_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Watched inputs
    input wire logic VCC_OK,
    input wire logic BUSY,
    input wire logic RESET_PIN_N,
    input wire logic CS_N,
    // Watched outputs
    input wire logic READY,
    input wire logic STANDBY,
    input wire logic IO_OE,
    input wire logic POR_OK,
    input wire logic REG_INIT,
    input wire logic ABORT,
    input wire logic CMD_VALID
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic warm_r;
    logic warm_nxt;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Cycles since the last accepted reset pulse
    always_comb begin
        cnt_nxt = (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001;
        warm_nxt = warm_r;
        if (REG_INIT && !ABORT) begin
            warm_nxt = 1'b0;
        end
        if (ABORT) begin
            cnt_nxt = 16'h0000;
            warm_nxt = POR_OK;
        end
    end
    // Counter registers
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= 16'h0000;
            warm_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            warm_r <= warm_nxt;
        end
    end
    // Interface kept out of service
    sequence quiet_s;
        !READY [*8];
    endsequence
    io_float_a: assert property (IO_OE |-> READY && !$past(CS_N, 3))
        else $error("IO_OE high while not ready");
    abort_init_a: assert property (ABORT |-> REG_INIT)
        else $error("ABORT without REG_INIT");
    abort_quiet_a: assert property (ABORT |=> quiet_s)
        else $error("READY too soon after ABORT");
    cold_quiet_a: assert property (REG_INIT && !ABORT |=> quiet_s)
        else $error("READY too soon after cold start");
    cmd_ready_a: assert property (CMD_VALID |-> READY)
        else $error("command taken while not ready");
    warm_len_a: assert property ($rose(READY) && warm_r |->
        cnt_r >= 16'h0159)
        else $error("warm reset too short");
    busy_stby_a: assert property (BUSY [*3] |-> !STANDBY)
        else $error("STANDBY while busy");
    vcc_off_a: assert property (!VCC_OK [*6] |-> !READY && !POR_OK)
        else $error("READY without supply");
    held_a: assert property (!RESET_PIN_N [*6] |-> !$rose(READY))
        else $error("READY rose with reset pin low");
endmodule

bind sfrs_top sfrs_top_checker sfrs_top_checker_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .VCC_OK(VCC_OK), .BUSY(BUSY),
    .RESET_PIN_N(RESET_PIN_N), .CS_N(CS_N), .READY(READY), .STANDBY(STANDBY),
    .IO_OE(IO_OE), .POR_OK(POR_OK), .REG_INIT(REG_INIT), .ABORT(ABORT),
    .CMD_VALID(CMD_VALID)
);

// [tb/tb.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/100ps
module tb;
    localparam int PU = 20;
    logic core_clk, rst_n, vcc_ok, por_fault, busy;
    logic cs_n, sck, si, reset_pin_n;
    logic ready, standby, io_oe, por_ok, reg_init, abort, cmd_valid;
    logic [7:0] cmd_opcode;
    logic [7:0] last_op;
    logic ab_seen, ri_seen, cv_seen, oe_seen;
    int err_total, checks_done;

    sfrs_top #(.PU_CYC(PU)) sfrs_top_inst (
        .CORE_CLK(core_clk), .RST_N(rst_n), .VCC_OK(vcc_ok),
        .POR_FAULT(por_fault), .RESET_PIN_N(reset_pin_n), .CS_N(cs_n),
        .SCK(sck), .SI(si), .BUSY(busy), .READY(ready),
        .STANDBY(standby), .IO_OE(io_oe), .POR_OK(por_ok),
        .REG_INIT(reg_init), .ABORT(abort), .CMD_VALID(cmd_valid),
        .CMD_OPCODE(cmd_opcode));
    sfrs_host_model sfrs_host_model_inst (.clk(core_clk), .cs_n(cs_n),
        .sck(sck), .si(si), .reset_pin_n(reset_pin_n));

    // Core clock
    always #50 core_clk = ~core_clk;
    // Sticky record of event pulses, read mid-cycle where they stand
    always @(negedge core_clk) begin
        if (abort === 1'b1) ab_seen = 1'b1;
        if (io_oe === 1'b1) oe_seen = 1'b1;
        if (reg_init === 1'b1) ri_seen = 1'b1;
        if (cmd_valid === 1'b1) begin
            cv_seen = 1'b1;
            last_op = cmd_opcode;
        end
    end

    task automatic stop_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_in(input string what, input int lo, input int hi,
            input int n);
        checks_done++;
        if (n < lo || n > hi) begin
            err_total++;
            $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, n);
        end
    endtask
    // Bounded wait for a READY level, counted in cycles
    task automatic wait_for(input logic v, output int n);
        n = 0;
        while (ready !== v) begin
            @(negedge core_clk);
            n++;
            if (n > 2000) begin
                err_total++;
                $display("Error READY expected %b seen %b", v, ready);
                stop_test();
            end
        end
    endtask

    task automatic t_power();
        int n;
        @(posedge core_clk);
        vcc_ok <= 1'b1;
        fork
            begin
                repeat (6) @(posedge core_clk);
                sfrs_host_model_inst.pulse(3);
            end
            wait_for(1'b1, n);
        join
        chk_in("cold length", PU, PU + 8, n);
        chk("ABORT", 8'h00, {7'h0, ab_seen});
        chk("REG_INIT", 8'h01, {7'h0, ri_seen});
        chk("POR_OK", 8'h01, {7'h0, por_ok});
    endtask
    task automatic t_cmd();
        logic [7:0] ops [3] = '{8'h0b, 8'h6c, 8'hec};
        foreach (ops[i]) begin
            cv_seen = 1'b0;
            oe_seen = 1'b0;
            sfrs_host_model_inst.frame(ops[i]);
            chk("CMD_VALID", 8'h01, {7'h0, cv_seen});
            chk("CMD_OPCODE", ops[i], last_op);
            chk("IO_OE frame", 8'h01, {7'h0, oe_seen});
        end
        @(posedge core_clk);
        busy <= 1'b1;
        repeat (4) @(negedge core_clk);
        chk("STANDBY busy", 8'h00, {7'h0, standby});
        @(posedge core_clk);
        busy <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk("STANDBY idle", 8'h01, {7'h0, standby});
        chk("IO_OE idle", 8'h00, {7'h0, io_oe});
    endtask
    task automatic t_reset(input int lo, input int hi);
        int m, n;
        ab_seen = 1'b0;
        ri_seen = 1'b0;
        fork
            sfrs_host_model_inst.pulse(3);
            begin
                wait_for(1'b0, m);
                wait_for(1'b1, n);
            end
        join
        chk_in("reset length", lo, hi, m + n);
        chk("ABORT", 8'h01, {7'h0, ab_seen});
        chk("REG_INIT", 8'h01, {7'h0, ri_seen});
    endtask
    task automatic t_fault();
        int n;
        @(posedge core_clk);
        vcc_ok <= 1'b0;
        por_fault <= 1'b1;
        repeat (8) @(negedge core_clk);
        chk("READY off", 8'h00, {7'h0, ready});
        @(posedge core_clk);
        vcc_ok <= 1'b1;
        wait_for(1'b1, n);
        chk("POR_OK", 8'h00, {7'h0, por_ok});
        @(posedge core_clk);
        por_fault <= 1'b0;
        t_reset(PU + 2, PU + 12);
        chk("POR_OK", 8'h01, {7'h0, por_ok});
    endtask
    task automatic t_held();
        int n;
        @(posedge core_clk);
        vcc_ok <= 1'b0;
        sfrs_host_model_inst.set_rst(1'b0);
        repeat (6) @(posedge core_clk);
        vcc_ok <= 1'b1;
        repeat (PU + 20) @(negedge core_clk);
        chk("READY held", 8'h00, {7'h0, ready});
        sfrs_host_model_inst.set_rst(1'b1);
        wait_for(1'b1, n);
        chk_in("held release", 1, 8, n);
    endtask

    // Main sequence
    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        vcc_ok = 1'b0;
        por_fault = 1'b0;
        busy = 1'b0;
        err_total = 0;
        checks_done = 0;
        ab_seen = 1'b0;
        ri_seen = 1'b0;
        cv_seen = 1'b0;
        oe_seen = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_power();
        t_cmd();
        sfrs_host_model_inst.pulse(1);
        repeat (6) @(negedge core_clk);
        chk("ABORT short", 8'h00, {7'h0, ab_seen});
        t_reset(350, 362);
        t_cmd();
        t_fault();
        t_held();
        stop_test();
    end
endmodule
